//--- hdl/ifm_evsync.sv
// Toggle-to-pulse and level synchronisers into the system domain
`timescale 1ns/1ps
`default_nettype none
module ifm_evsync (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // From the link domain
   input wire logic [ifm_pkg::N_EV-1:0] toggle_async,
   input wire logic level_async,
   // Into the system domain
   output logic [ifm_pkg::N_EV-1:0] pulse,
   output logic level_sync_ff
);
   import ifm_pkg::*;

   logic level_meta_ff;

   // One two-stage chain plus edge detect per event
   genvar g;
   generate
      for (g = 0; g < N_EV; g++) begin : g_ev
         logic meta_ff, sync_ff, last_ff;
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
               last_ff <= 1'b0;
            end else begin
               meta_ff <= toggle_async[g];
               sync_ff <= meta_ff;
               last_ff <= sync_ff;
            end
         end
         assign pulse[g] = sync_ff ^ last_ff;
      end
   endgenerate

   // Busy level, two stages
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         level_meta_ff <= 1'b0;
         level_sync_ff <= 1'b0;
      end else begin
         level_meta_ff <= level_async;
         level_sync_ff <= level_meta_ff;
      end
   end

endmodule // ifm_evsync
`default_nettype wire

//--- hdl/ifm_flags.sv
// Interrupt flags, mask and clear registers of the two-wire controller
`timescale 1ns/1ps
`default_nettype none
module ifm_flags (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Link clock
   input wire logic clk_link,
   // Link-domain events from the bus state machines
   input wire logic link_start,
   input wire logic link_stop,
   input wire logic link_broadcast_ack,
   input wire logic link_slave_nack,
   input wire logic link_abort,
   input wire logic [ifm_pkg::CAUSE_W-1:0] link_abort_cause,
   input wire logic link_read_req,
   input wire logic link_busy,
   // Clock line hold toward the link
   output logic scl_hold_low,
   // Register port
   input wire logic [ifm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ifm_pkg::DATA_W-1:0] reg_wdata,
   output logic [ifm_pkg::DATA_W-1:0] reg_rdata,
   // Transmit buffer side
   input wire logic [ifm_pkg::LEVEL_W-1:0] tx_level,
   output logic tx_fifo_flush,
   // Receive path steering
   output logic broadcast_rx_steer,
   // Status and interrupt
   output logic controller_on,
   output logic [ifm_pkg::DATA_W-1:0] masked_status,
   output logic irq
);
   import ifm_pkg::*;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------

   // Word match on the full address
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      hit = (addr == ofs);
   endfunction

   logic wr_mask, wr_tl, wr_enable;
   logic rd_all_clr, rd_bc_clr, rd_busy_clr, rd_rreq_clr, rd_abort_clr;

   // Write and clear-on-read strobes
   always_comb begin
      wr_mask = reg_wr && hit(reg_addr, OFS_INTERRUPT_MASK);
      wr_tl = reg_wr && hit(reg_addr, OFS_TX_THRESHOLD);
      wr_enable = reg_wr && hit(reg_addr, OFS_ENABLE);
      rd_all_clr = reg_rd && hit(reg_addr, OFS_ALL_FLAGS_CLEAR);
      rd_bc_clr = reg_rd && hit(reg_addr, OFS_BROADCAST_CLEAR);
      rd_busy_clr = reg_rd && hit(reg_addr, OFS_BUSY_CLEAR);
      rd_rreq_clr = reg_rd && hit(reg_addr, OFS_READ_REQ_CLEAR);
      rd_abort_clr = reg_rd && hit(reg_addr, OFS_ABORT_CLEAR);
   end

   // ---------------------------------------------------------------
   // Link crossing
   // ---------------------------------------------------------------

   logic [N_EV-1:0] link_ev;
   logic [N_EV-1:0] ev_toggle;
   logic [N_EV-1:0] ev;
   logic [CAUSE_W-1:0] cause_link;
   logic busy_link;
   logic busy_sys;
   logic read_req_ff;

   // Gather link events into one vector
   always_comb begin
      link_ev = '0;
      link_ev[EV_START] = link_start;
      link_ev[EV_STOP] = link_stop;
      link_ev[EV_BROADCAST] = link_broadcast_ack;
      link_ev[EV_SLV_NACK] = link_slave_nack;
      link_ev[EV_ABORT] = link_abort;
      link_ev[EV_READ_REQ] = link_read_req;
   end

   // Link-domain front end
   ifm_link u_link (
      .clk_link(clk_link),
      .rst(rst),
      .ev_pulse(link_ev),
      .abort_cause_in(link_abort_cause),
      .busy_in(link_busy),
      .hold_req_async(read_req_ff),
      .ev_toggle_ff(ev_toggle),
      .cause_hold_ff(cause_link),
      .busy_ff(busy_link),
      .scl_hold_low(scl_hold_low)
   );

   // Crossing into the system clock
   ifm_evsync u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .toggle_async(ev_toggle),
      .level_async(busy_link),
      .pulse(ev),
      .level_sync_ff(busy_sys)
   );

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------

   logic [15:0] mask_ff, nxt_mask;
   logic [4:0] tl_ff, nxt_tl;
   logic enable_ff, nxt_enable;

   // Mask, threshold and enable next values
   always_comb begin
      nxt_mask = mask_ff;
      nxt_tl = tl_ff;
      nxt_enable = enable_ff;
      if (wr_mask) begin
         nxt_mask = reg_wdata & MASK_WRITABLE;
      end
      if (wr_tl) begin
         nxt_tl = (reg_wdata[4:0] > TL_TOP) ? TL_TOP : reg_wdata[4:0];
      end
      if (wr_enable) begin
         nxt_enable = reg_wdata[BIT_ENABLE];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mask_ff <= MASK_RESET;
         tl_ff <= TL_RESET;
         enable_ff <= 1'b0;
      end else begin
         mask_ff <= nxt_mask;
         tl_ff <= nxt_tl;
         enable_ff <= nxt_enable;
      end
   end

   assign controller_on = enable_ff;

   // ---------------------------------------------------------------
   // Sticky flags
   // ---------------------------------------------------------------

   logic bc_ff, start_ff, stop_ff, busy_ff, done_ff, abort_ff;
   logic nxt_bc, nxt_start, nxt_stop, nxt_busy, nxt_done, nxt_abort, nxt_read_req;
   logic steer_ff, nxt_steer;
   logic [CAUSE_W-1:0] cause_ff, nxt_cause;
   logic any_activity;

   // Clears first, then sets so an event in a clear cycle survives
   always_comb begin
      any_activity = busy_sys || (|ev);
      nxt_bc = bc_ff;
      nxt_start = start_ff;
      nxt_stop = stop_ff;
      nxt_busy = busy_ff;
      nxt_done = done_ff;
      nxt_abort = abort_ff;
      nxt_read_req = read_req_ff;
      nxt_steer = steer_ff;
      nxt_cause = cause_ff;
      if (rd_all_clr) begin
         nxt_bc = 1'b0;
         nxt_start = 1'b0;
         nxt_stop = 1'b0;
         nxt_busy = 1'b0;
         nxt_done = 1'b0;
         nxt_abort = 1'b0;
         nxt_read_req = 1'b0;
      end
      if (rd_bc_clr || !enable_ff) begin
         nxt_bc = 1'b0;
      end
      if (rd_busy_clr || !enable_ff) begin
         nxt_busy = 1'b0;
      end
      if (rd_rreq_clr) begin
         nxt_read_req = 1'b0;
      end
      if (rd_abort_clr) begin
         nxt_abort = 1'b0;
      end
      if (ev[EV_STOP] || !enable_ff) begin
         nxt_steer = 1'b0;
      end
      // A disabled controller acknowledges no general call
      if (ev[EV_BROADCAST] && enable_ff) begin
         nxt_bc = 1'b1;
         nxt_steer = 1'b1;
      end
      if (ev[EV_START]) begin
         nxt_start = 1'b1;
      end
      if (ev[EV_STOP]) begin
         nxt_stop = 1'b1;
      end
      if (any_activity && enable_ff) begin
         nxt_busy = 1'b1;
      end
      if (ev[EV_SLV_NACK]) begin
         nxt_done = 1'b1;
      end
      if (ev[EV_ABORT]) begin
         nxt_abort = 1'b1;
         nxt_cause = cause_link;
      end
      if (ev[EV_READ_REQ]) begin
         nxt_read_req = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bc_ff <= 1'b0;
         start_ff <= 1'b0;
         stop_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         abort_ff <= 1'b0;
         read_req_ff <= 1'b0;
         steer_ff <= 1'b0;
         cause_ff <= '0;
      end else begin
         bc_ff <= nxt_bc;
         start_ff <= nxt_start;
         stop_ff <= nxt_stop;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         abort_ff <= nxt_abort;
         read_req_ff <= nxt_read_req;
         steer_ff <= nxt_steer;
         cause_ff <= nxt_cause;
      end
   end

   assign broadcast_rx_steer = steer_ff;

   // ---------------------------------------------------------------
   // Transmit buffer gate
   // ---------------------------------------------------------------

   ifm_txf_t txf_ff, nxt_txf;

   // Off while disabled, flush while aborted, run otherwise
   // Follows the next enable so flush starts at the disabling edge
   always_comb begin
      nxt_txf = txf_ff;
      case (txf_ff)
         IFM_TXF_RUN: begin
            if (!nxt_enable) begin
               nxt_txf = IFM_TXF_OFF;
            end else if (nxt_abort) begin
               nxt_txf = IFM_TXF_FLUSH;
            end
         end
         IFM_TXF_FLUSH: begin
            if (!nxt_enable) begin
               nxt_txf = IFM_TXF_OFF;
            end else if (!nxt_abort) begin
               nxt_txf = IFM_TXF_RUN;
            end
         end
         IFM_TXF_OFF: begin
            if (nxt_enable) begin
               nxt_txf = nxt_abort ? IFM_TXF_FLUSH : IFM_TXF_RUN;
            end
         end
         default: begin
            nxt_txf = IFM_TXF_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txf_ff <= IFM_TXF_OFF;
      end else begin
         txf_ff <= nxt_txf;
      end
   end

   assign tx_fifo_flush = (txf_ff != IFM_TXF_RUN);

   // ---------------------------------------------------------------
   // Transmit threshold flag
   // ---------------------------------------------------------------

   logic [5:0] tl_entries;
   logic tx_low_ff, nxt_tx_low;

   // Level compare; disabled buffer reads empty only while busy
   always_comb begin
      tl_entries = (tl_ff == TL_TOP) ? TX_DEPTH : {1'b0, tl_ff};
      if (!enable_ff) begin
         nxt_tx_low = busy_sys;
      end else begin
         nxt_tx_low = (tx_level <= tl_entries);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_low_ff <= 1'b0;
      end else begin
         tx_low_ff <= nxt_tx_low;
      end
   end

   // ---------------------------------------------------------------
   // Raw and masked status
   // ---------------------------------------------------------------

   logic [15:0] raw_status;

   // Bits 3:0 belong to the receive path and read zero here
   always_comb begin
      raw_status = '0;
      raw_status[BIT_BROADCAST] = bc_ff;
      raw_status[BIT_START] = start_ff;
      raw_status[BIT_STOP] = stop_ff;
      raw_status[BIT_BUSY] = busy_ff;
      raw_status[BIT_SLV_DONE] = done_ff;
      raw_status[BIT_ABORT] = abort_ff;
      raw_status[BIT_READ_REQ] = read_req_ff;
      raw_status[BIT_TX_LOW] = tx_low_ff;
   end

   assign masked_status = raw_status & mask_ff;
   assign irq = |masked_status;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------

   logic [15:0] rdata_ff, nxt_rdata;

   // Clear registers return the flag as it stood before the read
   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_rd) begin
         case (reg_addr)
            OFS_MASKED_STATUS: nxt_rdata = masked_status;
            OFS_INTERRUPT_MASK: nxt_rdata = mask_ff;
            OFS_RAW_STATUS: nxt_rdata = raw_status;
            OFS_TX_THRESHOLD: nxt_rdata = {11'h000, tl_ff};
            OFS_ALL_FLAGS_CLEAR: nxt_rdata = {15'h0000, |raw_status};
            OFS_BROADCAST_CLEAR: nxt_rdata = {15'h0000, bc_ff};
            OFS_BUSY_CLEAR: nxt_rdata = {15'h0000, busy_ff};
            OFS_READ_REQ_CLEAR: nxt_rdata = {15'h0000, read_req_ff};
            OFS_ABORT_CLEAR: nxt_rdata = {15'h0000, abort_ff};
            OFS_ABORT_CAUSE: nxt_rdata = cause_ff;
            OFS_ENABLE: nxt_rdata = {15'h0000, enable_ff};
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule // ifm_flags
`default_nettype wire

//--- hdl/ifm_link.sv
// Link-domain front end: event toggles, busy level, abort cause, clock hold
`timescale 1ns/1ps
`default_nettype none
module ifm_link (
   // Link clock and reset
   input wire logic clk_link,
   input wire logic rst,
   // Events from the bus state machines
   input wire logic [ifm_pkg::N_EV-1:0] ev_pulse,
   input wire logic [ifm_pkg::CAUSE_W-1:0] abort_cause_in,
   input wire logic busy_in,
   // Hold request from the system domain
   input wire logic hold_req_async,
   // Toward the system domain
   output logic [ifm_pkg::N_EV-1:0] ev_toggle_ff,
   output logic [ifm_pkg::CAUSE_W-1:0] cause_hold_ff,
   output logic busy_ff,
   // Clock line hold
   output logic scl_hold_low
);
   import ifm_pkg::*;

   logic [N_EV-1:0] nxt_ev_toggle;
   logic [CAUSE_W-1:0] nxt_cause_hold;
   logic req_meta_ff, req_sync_ff, hold_ff, armed_ff;
   logic nxt_hold, nxt_armed;

   // Toggles, cause capture and hold tracking
   always_comb begin
      nxt_ev_toggle = ev_toggle_ff ^ ev_pulse;
      nxt_cause_hold = ev_pulse[EV_ABORT] ? abort_cause_in : cause_hold_ff;
      nxt_hold = hold_ff;
      nxt_armed = armed_ff;
      if (hold_ff && req_sync_ff) begin
         nxt_armed = 1'b1;
      end
      if (hold_ff && armed_ff && !req_sync_ff) begin
         nxt_hold = 1'b0;
         nxt_armed = 1'b0;
      end
      if (ev_pulse[EV_READ_REQ]) begin
         nxt_hold = 1'b1;
      end
   end

   always_ff @(posedge clk_link or posedge rst) begin
      if (rst) begin
         ev_toggle_ff <= '0;
         cause_hold_ff <= '0;
         busy_ff <= 1'b0;
         req_meta_ff <= 1'b0;
         req_sync_ff <= 1'b0;
         hold_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         ev_toggle_ff <= nxt_ev_toggle;
         cause_hold_ff <= nxt_cause_hold;
         busy_ff <= busy_in;
         req_meta_ff <= hold_req_async;
         req_sync_ff <= req_meta_ff;
         hold_ff <= nxt_hold;
         armed_ff <= nxt_armed;
      end
   end

   assign scl_hold_low = hold_ff;

endmodule // ifm_link
`default_nettype wire

//--- shared/ifm_pkg.sv
// Constants and types shared by the interrupt flag and mask logic
package ifm_pkg;

   // ---------------------------------------------------------------
   // Register port widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int DATA_W = 16;
   localparam int CAUSE_W = 16;
   localparam int LEVEL_W = 6;
   localparam int TL_W = 5;

   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [31:0] OFS_MASKED_STATUS = 32'h5000132C;
   localparam logic [31:0] OFS_INTERRUPT_MASK = 32'h50001330;
   localparam logic [31:0] OFS_RAW_STATUS = 32'h50001334;
   localparam logic [31:0] OFS_TX_THRESHOLD = 32'h5000133C;
   localparam logic [31:0] OFS_ALL_FLAGS_CLEAR = 32'h50001340;
   localparam logic [31:0] OFS_BROADCAST_CLEAR = 32'h50001344;
   localparam logic [31:0] OFS_BUSY_CLEAR = 32'h50001348;
   localparam logic [31:0] OFS_READ_REQ_CLEAR = 32'h5000134C;
   localparam logic [31:0] OFS_ABORT_CLEAR = 32'h50001350;
   localparam logic [31:0] OFS_ABORT_CAUSE = 32'h50001354;
   localparam logic [31:0] OFS_ENABLE = 32'h50001358;

   // ---------------------------------------------------------------
   // Flag bit positions
   // ---------------------------------------------------------------
   localparam int BIT_BROADCAST = 11;
   localparam int BIT_START = 10;
   localparam int BIT_STOP = 9;
   localparam int BIT_BUSY = 8;
   localparam int BIT_SLV_DONE = 7;
   localparam int BIT_ABORT = 6;
   localparam int BIT_READ_REQ = 5;
   localparam int BIT_TX_LOW = 4;
   localparam int BIT_ENABLE = 0;

   // ---------------------------------------------------------------
   // Reset values and writable masks
   // ---------------------------------------------------------------
   localparam logic [15:0] MASK_RESET = 16'h08FF;
   localparam logic [15:0] MASK_WRITABLE = 16'h0FFF;
   localparam logic [4:0] TL_RESET = 5'h00;
   localparam logic [4:0] TL_TOP = 5'h1F;
   localparam logic [5:0] TX_DEPTH = 6'h20;

   // ---------------------------------------------------------------
   // Link events crossing into the system domain
   // ---------------------------------------------------------------
   localparam int EV_START = 0;
   localparam int EV_STOP = 1;
   localparam int EV_BROADCAST = 2;
   localparam int EV_SLV_NACK = 3;
   localparam int EV_ABORT = 4;
   localparam int EV_READ_REQ = 5;
   localparam int N_EV = 6;

   // Transmit buffer gate states, Gray along run - flush - off
   typedef enum logic [1:0] {
      IFM_TXF_RUN = 2'b00,
      IFM_TXF_FLUSH = 2'b01,
      IFM_TXF_OFF = 2'b11
   } ifm_txf_t;

endpackage

//--- tb/ifm_flags_checker.sv
// Checker of the flag and mask logic at its register and status ports
`timescale 1ns/1ps
`default_nettype none
module ifm_flags_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [ifm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ifm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [ifm_pkg::DATA_W-1:0] reg_rdata,
   // Status outputs
   input wire logic tx_fifo_flush,
   input wire logic broadcast_rx_steer,
   input wire logic controller_on,
   input wire logic [ifm_pkg::DATA_W-1:0] masked_status,
   input wire logic irq
);
   import ifm_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ---------------------------------------------------------------
   // Port relations
   // ---------------------------------------------------------------
   property p_irq_or;
      irq == (|masked_status);
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq differs from OR of masked bits");
   property p_resv_masked;
      masked_status[15:12] == 4'h0;
   endproperty
   a_resv_masked: assert property (p_resv_masked) else $error("reserved masked bits set");
   property p_resv_read;
      reg_rd && reg_addr == OFS_INTERRUPT_MASK |=> reg_rdata[15:12] == 4'h0;
   endproperty
   a_resv_read: assert property (p_resv_read) else $error("reserved mask bits read nonzero");
   property p_flush_off;
      !controller_on |-> tx_fifo_flush;
   endproperty
   a_flush_off: assert property (p_flush_off) else $error("buffer not flushed while off");
   property p_abort_flush;
      masked_status[BIT_ABORT] |-> tx_fifo_flush;
   endproperty
   a_abort_flush: assert property (p_abort_flush) else $error("buffer not flushed on abort");
   property p_en_bit;
      reg_wr && reg_addr == OFS_ENABLE |=> controller_on == $past(reg_wdata[0]);
   endproperty
   a_en_bit: assert property (p_en_bit) else $error("enable bit not taken");
   property p_rdreq_clr;
      reg_rd && reg_addr == OFS_READ_REQ_CLEAR |=> !masked_status[BIT_READ_REQ];
   endproperty
   a_rdreq_clr: assert property (p_rdreq_clr) else $error("read request not cleared");
   property p_all_clr;
      reg_rd && reg_addr == OFS_ALL_FLAGS_CLEAR |=> masked_status[11:5] == 7'h00;
   endproperty
   a_all_clr: assert property (p_all_clr) else $error("flags kept after clear all");
   property p_off_clr;
      $fell(controller_on) |=> !masked_status[11] && !masked_status[8] && !broadcast_rx_steer;
   endproperty
   a_off_clr: assert property (p_off_clr) else $error("disable left flags set");
   property p_rdata_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
endmodule // ifm_flags_checker
bind ifm_flags ifm_flags_checker chk_u (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_fifo_flush(tx_fifo_flush),
   .broadcast_rx_steer(broadcast_rx_steer), .controller_on(controller_on),
   .masked_status(masked_status), .irq(irq)
);
`default_nettype wire

//--- tb/ifm_flags_test.sv
// Self-checking bench of the interrupt flag and mask logic
`timescale 1ns/1ps
`default_nettype none
module ifm_flags_test;
   import ifm_pkg::*;
   logic clk_sys = 1'b0;
   logic clk_link = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic [LEVEL_W-1:0] tx_level = 6'h20;
   logic [DATA_W-1:0] reg_rdata, masked_status;
   logic scl_hold_low, tx_fifo_flush, broadcast_rx_steer, controller_on, irq, busy;
   logic [N_EV-1:0] ev;
   logic [CAUSE_W-1:0] cause;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   int evs[6] = '{EV_START, EV_STOP, EV_SLV_NACK, EV_ABORT, EV_READ_REQ, EV_BROADCAST};
   int bits[6] = '{BIT_START, BIT_STOP, BIT_SLV_DONE, BIT_ABORT, BIT_READ_REQ, BIT_BROADCAST};
   logic [31:0] clrs[6] = '{OFS_ALL_FLAGS_CLEAR, OFS_ALL_FLAGS_CLEAR, OFS_ALL_FLAGS_CLEAR,
                            OFS_ABORT_CLEAR, OFS_READ_REQ_CLEAR, OFS_BROADCAST_CLEAR};
   logic [4:0] tls[4] = '{5'h05, 5'h05, 5'h1F, 5'h00};
   logic [5:0] lvls[4] = '{6'h05, 6'h06, 6'h20, 6'h01};
   logic exb[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   // Clocks, link clock offset in phase
   always #5 clk_sys = ~clk_sys;
   initial begin
      #1.3;
      forever #3 clk_link = ~clk_link;
   end
   ifm_link_model link_u (.clk_link(clk_link), .ev(ev), .cause(cause), .busy(busy));
   ifm_flags dut_u (
      .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
      .link_start(ev[EV_START]), .link_stop(ev[EV_STOP]),
      .link_broadcast_ack(ev[EV_BROADCAST]), .link_slave_nack(ev[EV_SLV_NACK]),
      .link_abort(ev[EV_ABORT]), .link_abort_cause(cause), .link_read_req(ev[EV_READ_REQ]),
      .link_busy(busy), .scl_hold_low(scl_hold_low), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_level(tx_level),
      .tx_fifo_flush(tx_fifo_flush), .broadcast_rx_steer(broadcast_rx_steer),
      .controller_on(controller_on), .masked_status(masked_status), .irq(irq)
   );
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic complete_run;
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      cmp(reg_rdata, exp, what);
   endtask
   // Cycle ceiling against a hang
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      wt(20);
      rst = 1'b0;
      rdc(OFS_INTERRUPT_MASK, MASK_RESET, "mask reset");
      rdc(OFS_RAW_STATUS, 16'h0000, "raw reset");
      wr(OFS_INTERRUPT_MASK, 16'hFFFF);
      rdc(OFS_INTERRUPT_MASK, MASK_WRITABLE, "mask reserved");
      rdc(32'h50001400, 16'h0000, "unmapped");
      link_u.send(EV_BROADCAST, 16'h0000);
      wt(8);
      rdc(OFS_RAW_STATUS, 16'h0000, "broadcast while off");
      wr(OFS_ENABLE, 16'h0001);
      wt(4);
      cmp(tx_fifo_flush, 1'b0, "flush when on");
      rdc(OFS_ENABLE, 16'h0001, "enable read");
      for (int i = 0; i < 6; i++) begin
         link_u.send(evs[i], 16'hA5C3);
         wt(8);
         rdc(OFS_RAW_STATUS, (16'h0001 << bits[i]) | 16'h0100, "raw set");
         cmp(irq, 1'b1, "irq");
         if (evs[i] == EV_ABORT) begin
            cmp(tx_fifo_flush, 1'b1, "abort flush");
            rdc(OFS_ABORT_CAUSE, 16'hA5C3, "cause");
         end
         if (evs[i] == EV_READ_REQ) cmp(scl_hold_low, 1'b1, "clock hold");
         if (evs[i] == EV_BROADCAST) cmp(broadcast_rx_steer, 1'b1, "steer");
         rdc(OFS_BUSY_CLEAR, 16'h0001, "event busy");
         rdc(clrs[i], 16'h0001, "clear read");
         rdc(OFS_RAW_STATUS, 16'h0000, "raw cleared");
         wt(6);
         cmp(tx_fifo_flush | scl_hold_low, 1'b0, "released");
      end
      link_u.set_busy(1'b1);
      wt(8);
      link_u.set_busy(1'b0);
      wt(8);
      rdc(OFS_RAW_STATUS, 16'h0100, "busy sticky");
      rdc(OFS_BUSY_CLEAR, 16'h0001, "busy clear");
      rdc(OFS_RAW_STATUS, 16'h0000, "busy cleared");
      for (int i = 0; i < 4; i++) begin
         wr(OFS_TX_THRESHOLD, {11'h000, tls[i]});
         rdc(OFS_TX_THRESHOLD, {11'h000, tls[i]}, "threshold");
         tx_level = lvls[i];
         wt(3);
         rdc(OFS_RAW_STATUS, {11'h000, exb[i], 4'h0}, "tx low");
      end
      tx_level = 6'h00;
      wt(3);
      cmp(masked_status, 16'h0010, "masked");
      rdc(OFS_MASKED_STATUS, 16'h0010, "masked read");
      wr(OFS_INTERRUPT_MASK, 16'hFFEF);
      cmp(irq, 1'b0, "irq masked");
      wr(OFS_ENABLE, 16'h0000);
      tx_level = 6'h20;
      link_u.set_busy(1'b1);
      wt(8);
      rdc(OFS_RAW_STATUS, 16'h0010, "off active");
      cmp(tx_fifo_flush, 1'b1, "flush off");
      link_u.set_busy(1'b0);
      wt(8);
      rdc(OFS_RAW_STATUS, 16'h0000, "off idle");
      complete_run();
   end
endmodule // ifm_flags_test
`default_nettype wire

//--- tb/ifm_link_model.sv
// Link-side model: event pulses and activity level on the link clock
`timescale 1ns/1ps
`default_nettype none
module ifm_link_model (
   // Link clock
   input wire logic clk_link,
   // Toward the controller
   output logic [ifm_pkg::N_EV-1:0] ev,
   output logic [ifm_pkg::CAUSE_W-1:0] cause,
   output logic busy
);
   import ifm_pkg::*;
   // Idle lines at time zero
   initial begin
      ev = '0;
      cause = 16'h0000;
      busy = 1'b0;
   end
   // One link cycle pulse, cause valid with it only
   task automatic send(input int idx, input logic [CAUSE_W-1:0] c);
      @(negedge clk_link);
      ev[idx] = 1'b1;
      cause = c;
      @(negedge clk_link);
      ev = '0;
      cause = ~c;
   endtask
   // State machine activity level
   task automatic set_busy(input logic b);
      @(negedge clk_link);
      busy = b;
   endtask
endmodule // ifm_link_model
`default_nettype wire
